// *** rtl/eit_regs.svh ***
`ifndef EIT_REGS_SVH
`define EIT_REGS_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define EIT_ADDR_W      4
`define EIT_DATA_W      16
`define EIT_CNT_W       16
`define EIT_PRE_W       8
`define EIT_OFF_CTRL    4'h0
`define EIT_OFF_STATUS  4'h1
`define EIT_OFF_CLEAR   4'h2
`define EIT_OFF_ENABLE  4'h3
`define EIT_OFF_CNT_A   4'h4
`define EIT_OFF_CNT_B   4'h5

// ---------------------------------------------------------------
// Reset values and pin indices
// ---------------------------------------------------------------
`define EIT_RST_CTRL    8'h00
`define EIT_RST_STATUS  4'h0
`define EIT_RST_ENABLE  4'h0
`define EIT_RST_CNT     16'h0000
`define EIT_RST_PINS    4'hf
`define EIT_RST_PRE     8'h00
`define EIT_RST_RDATA   16'h0000
`define EIT_PIN_CNT_LSB 2

`endif

// *** rtl/eit_pkg.sv ***
package eit_pkg;

    // Control register layout, bit 0 at the bottom
    typedef struct packed {
        logic [1:0] cnt_mode;
        logic [1:0] run;
        logic [1:0] run_gate_select;
        logic [1:0] edge_select;
    } eit_ctrl_s;

    // Sticky events: index 0 is channel a
    typedef struct packed {
        logic [1:0] ovf;
        logic [1:0] ext_irq_flag;
    } eit_stat_s;

    typedef struct packed {
        logic [3:0]       sync1;
        logic [3:0]       sync2;
        logic [3:0]       prev;
        eit_ctrl_s        ctrl;
        eit_stat_s        status;
        eit_stat_s        enable;
        logic [1:0][15:0] cnt;
        logic [7:0]       pre;
        logic             tick;
        logic [15:0]      rdata;
    } eit_state_s;

endpackage

// *** rtl/eit_inputs.sv ***
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "eit_regs.svh"

// What this block does
// - Edge mode a: falling edge on interrupt pin a sets flag a.
// - Level mode a: low level sampled on interrupt pin a sets flag a.
// - Edge mode b: falling edge on interrupt pin b sets flag b.
// - Level mode b: low level sampled on interrupt pin b sets flag b.
// - Gate select a: timer a runs only while interrupt pin a is high.
// - Gate select b: timer b runs only while interrupt pin b is high.
// - Counter mode a: each falling edge on count pin a adds one.
// - Counter mode b: each falling edge on count pin b adds one.
module eit_inputs #(
    parameter logic [7:0] PRESCALE = 8'h0c
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   ext_irq_pin_a_i,
    input  wire logic                   ext_irq_pin_b_i,
    input  wire logic                   count_pin_a_i,
    input  wire logic                   count_pin_b_i,
    input  wire logic [`EIT_ADDR_W-1:0] addr_i,
    input  wire logic [`EIT_DATA_W-1:0] wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [`EIT_DATA_W-1:0] rdata_o,
    output logic                        irq_o,
    output logic                        ext_irq_flag_a_o,
    output logic                        ext_irq_flag_b_o
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    eit_pkg::eit_state_s st_ff;
    eit_pkg::eit_state_s nxt_st;

    logic [3:0] pins;
    logic [3:0] fall;
    logic [1:0] set_irq;
    logic [1:0] run_en;
    logic [1:0] inc;
    logic [1:0] ovf_hit;
    logic [1:0] cnt_wr;
    logic       ctrl_wr;
    logic       clr_wr;
    logic       en_wr;

    // Pin order: irq a, irq b, count a, count b
    assign pins = {count_pin_b_i, count_pin_a_i, ext_irq_pin_b_i, ext_irq_pin_a_i};

    // Only the second and third stages are looked at
    assign fall = st_ff.prev & ~st_ff.sync2;

    assign ctrl_wr   = wr_i && (addr_i == `EIT_OFF_CTRL);
    assign clr_wr    = wr_i && (addr_i == `EIT_OFF_CLEAR);
    assign en_wr     = wr_i && (addr_i == `EIT_OFF_ENABLE);
    assign cnt_wr[0] = wr_i && (addr_i == `EIT_OFF_CNT_A);
    assign cnt_wr[1] = wr_i && (addr_i == `EIT_OFF_CNT_B);

    // ---------------------------------------------------------------
    // Per-channel event logic
    // ---------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_chan
        // Edge select chooses falling edge or low level
        assign set_irq[i] = st_ff.ctrl.edge_select[i] ? fall[i]
                                                      : ~st_ff.sync2[i];
        // Gate mode: the run bit takes effect only while the interrupt pin is high
        assign run_en[i] = st_ff.ctrl.run[i] &&
                           (!st_ff.ctrl.run_gate_select[i] || st_ff.sync2[i]);
        // Counter mode counts count-pin edges, timer mode counts prescaler ticks
        assign inc[i] = run_en[i] && (st_ff.ctrl.cnt_mode[i] ?
                        fall[`EIT_PIN_CNT_LSB + i] : st_ff.tick);
        assign ovf_hit[i] = inc[i] && !cnt_wr[i] && (&st_ff.cnt[i]);
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;

        // Synchronisers, then a third stage for edge detection
        nxt_st.sync1 = pins;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.prev  = st_ff.sync2;

        // Timer-mode rate as a one-cycle enable pulse
        if (st_ff.pre == PRESCALE - 8'h01) begin
            nxt_st.pre  = `EIT_RST_PRE;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.pre  = st_ff.pre + 8'h01;
            nxt_st.tick = 1'b0;
        end

        // Software load beats a same-cycle increment
        for (int i = 0; i < 2; i++) begin
            if (cnt_wr[i]) begin
                nxt_st.cnt[i] = wdata_i;
            end else if (inc[i]) begin
                nxt_st.cnt[i] = st_ff.cnt[i] + 16'h0001;
            end
        end

        if (ctrl_wr) begin
            nxt_st.ctrl = wdata_i[7:0];
        end
        if (en_wr) begin
            nxt_st.enable = wdata_i[3:0];
        end

        // Set wins over clear so no event is lost
        nxt_st.status = clr_wr ? (st_ff.status & ~wdata_i[3:0]) : st_ff.status;
        nxt_st.status.ext_irq_flag = nxt_st.status.ext_irq_flag | set_irq;
        nxt_st.status.ovf = nxt_st.status.ovf | ovf_hit;

        // Read data stands only in the cycle after the strobe
        nxt_st.rdata = `EIT_RST_RDATA;
        if (rd_i) begin
            unique case (addr_i)
                `EIT_OFF_CTRL:   nxt_st.rdata = {8'h00, st_ff.ctrl};
                `EIT_OFF_STATUS: nxt_st.rdata = {12'h000, st_ff.status};
                `EIT_OFF_ENABLE: nxt_st.rdata = {12'h000, st_ff.enable};
                `EIT_OFF_CNT_A:  nxt_st.rdata = st_ff.cnt[0];
                `EIT_OFF_CNT_B:  nxt_st.rdata = st_ff.cnt[1];
                default:         nxt_st.rdata = `EIT_RST_RDATA;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff.sync1  <= `EIT_RST_PINS;
            st_ff.sync2  <= `EIT_RST_PINS;
            st_ff.prev   <= `EIT_RST_PINS;
            st_ff.ctrl   <= `EIT_RST_CTRL;
            st_ff.status <= `EIT_RST_STATUS;
            st_ff.enable <= `EIT_RST_ENABLE;
            st_ff.cnt[0] <= `EIT_RST_CNT;
            st_ff.cnt[1] <= `EIT_RST_CNT;
            st_ff.pre    <= `EIT_RST_PRE;
            st_ff.tick   <= 1'b0;
            st_ff.rdata  <= `EIT_RST_RDATA;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign rdata_o          = st_ff.rdata;
    assign irq_o            = |(st_ff.status & st_ff.enable);
    assign ext_irq_flag_a_o = st_ff.status.ext_irq_flag[0];
    assign ext_irq_flag_b_o = st_ff.status.ext_irq_flag[1];

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Falling edge seen on pin a sets flag a at the next edge
    chk_edge_flag_a: assert property (
        st_ff.ctrl.edge_select[0] && !ctrl_wr
        ##0 $fell(st_ff.sync2[0]) |=> st_ff.status.ext_irq_flag[0])
        else $error("Edge on pin a did not set flag a");

    chk_level_flag_a: assert property (
        !st_ff.ctrl.edge_select[0] && !st_ff.sync2[0]
        |=> st_ff.status.ext_irq_flag[0])
        else $error("Low level on pin a did not set flag a");

    chk_edge_flag_b: assert property (
        st_ff.ctrl.edge_select[1] && !ctrl_wr
        ##0 $fell(st_ff.sync2[1]) |=> st_ff.status.ext_irq_flag[1])
        else $error("Edge on pin b did not set flag b");

    chk_level_flag_b: assert property (
        !st_ff.ctrl.edge_select[1] && !st_ff.sync2[1]
        |=> st_ff.status.ext_irq_flag[1])
        else $error("Low level on pin b did not set flag b");

    // Edge mode with a steady high pin never raises a cleared flag
    chk_edge_quiet_a: assert property (
        st_ff.ctrl.edge_select[0] && st_ff.sync2[0] && st_ff.prev[0]
        && !st_ff.status.ext_irq_flag[0] |=> !st_ff.status.ext_irq_flag[0])
        else $error("Flag a set without an edge");

    chk_gate_hold_a: assert property (
        st_ff.ctrl.run_gate_select[0] && !st_ff.sync2[0] && !cnt_wr[0]
        |=> $stable(st_ff.cnt[0]))
        else $error("Timer a moved while its gate pin was low");

    chk_gate_hold_b: assert property (
        st_ff.ctrl.run_gate_select[1] && !st_ff.sync2[1] && !cnt_wr[1]
        |=> $stable(st_ff.cnt[1]))
        else $error("Timer b moved while its gate pin was low");

    chk_count_edge_a: assert property (
        st_ff.ctrl.cnt_mode[0] && run_en[0] && fall[`EIT_PIN_CNT_LSB] && !cnt_wr[0]
        |=> st_ff.cnt[0] == $past(st_ff.cnt[0]) + 16'h0001)
        else $error("Counter a missed a count-pin edge");

    chk_count_idle_a: assert property (
        st_ff.ctrl.cnt_mode[0] && !fall[`EIT_PIN_CNT_LSB] && !cnt_wr[0]
        |=> $stable(st_ff.cnt[0]))
        else $error("Counter a moved without an edge");

    chk_count_edge_b: assert property (
        st_ff.ctrl.cnt_mode[1] && run_en[1] && fall[`EIT_PIN_CNT_LSB + 1] && !cnt_wr[1]
        |=> st_ff.cnt[1] == $past(st_ff.cnt[1]) + 16'h0001)
        else $error("Counter b missed a count-pin edge");

    chk_sync_depth: assert property (
        $fell(st_ff.prev[`EIT_PIN_CNT_LSB]) |-> $past(st_ff.sync1[`EIT_PIN_CNT_LSB], 2) == 1'b0)
        else $error("Count pin a reached edge logic through too few stages");

    chk_rdata_gap: assert property (
        !rd_i |=> rdata_o == `EIT_RST_RDATA)
        else $error("Read data stood outside its cycle");

    chk_edge_quiet_b: assert property (
        st_ff.ctrl.edge_select[1] && st_ff.sync2[1] && st_ff.prev[1]
        && !st_ff.status.ext_irq_flag[1] |=> !st_ff.status.ext_irq_flag[1])
        else $error("Flag b set without an edge");

    // Level mode with a high pin never raises a cleared flag
    chk_level_quiet_a: assert property (
        !st_ff.ctrl.edge_select[0] && st_ff.sync2[0]
        && !st_ff.status.ext_irq_flag[0] |=> !st_ff.status.ext_irq_flag[0])
        else $error("Flag a set while pin a was high");

    chk_level_quiet_b: assert property (
        !st_ff.ctrl.edge_select[1] && st_ff.sync2[1]
        && !st_ff.status.ext_irq_flag[1] |=> !st_ff.status.ext_irq_flag[1])
        else $error("Flag b set while pin b was high");

    chk_sync_irq_a: assert property (
        $fell(st_ff.prev[0]) |-> $past(st_ff.sync1[0], 2) == 1'b0)
        else $error("Interrupt pin a reached edge logic through too few stages");

    chk_sync_irq_b: assert property (
        $fell(st_ff.prev[1]) |-> $past(st_ff.sync1[1], 2) == 1'b0)
        else $error("Interrupt pin b reached edge logic through too few stages");

    chk_sync_depth_b: assert property (
        $fell(st_ff.prev[`EIT_PIN_CNT_LSB + 1])
        |-> $past(st_ff.sync1[`EIT_PIN_CNT_LSB + 1], 2) == 1'b0)
        else $error("Count pin b reached edge logic through too few stages");

    // ---------------------------------------------------------------
    // Timer checks
    // ---------------------------------------------------------------

    chk_count_idle_b: assert property (
        st_ff.ctrl.cnt_mode[1] && !fall[`EIT_PIN_CNT_LSB + 1] && !cnt_wr[1]
        |=> $stable(st_ff.cnt[1]))
        else $error("Counter b moved without an edge");

    // Open gate lets prescaler ticks through in timer mode
    chk_gate_run_a: assert property (
        st_ff.ctrl.run[0] && st_ff.ctrl.run_gate_select[0] && st_ff.sync2[0]
        && !st_ff.ctrl.cnt_mode[0] && st_ff.tick && !cnt_wr[0]
        |=> st_ff.cnt[0] == $past(st_ff.cnt[0]) + 16'h0001)
        else $error("Timer a stood still with its gate pin high");

    chk_gate_run_b: assert property (
        st_ff.ctrl.run[1] && st_ff.ctrl.run_gate_select[1] && st_ff.sync2[1]
        && !st_ff.ctrl.cnt_mode[1] && st_ff.tick && !cnt_wr[1]
        |=> st_ff.cnt[1] == $past(st_ff.cnt[1]) + 16'h0001)
        else $error("Timer b stood still with its gate pin high");

    // A step from all ones wraps to zero and raises overflow
    chk_wrap_a: assert property (
        inc[0] && !cnt_wr[0] && (&st_ff.cnt[0])
        |=> st_ff.cnt[0] == `EIT_RST_CNT && st_ff.status.ovf[0])
        else $error("Counter a did not wrap into overflow");

    chk_wrap_b: assert property (
        inc[1] && !cnt_wr[1] && (&st_ff.cnt[1])
        |=> st_ff.cnt[1] == `EIT_RST_CNT && st_ff.status.ovf[1])
        else $error("Counter b did not wrap into overflow");

    chk_load_a: assert property (
        cnt_wr[0] |=> st_ff.cnt[0] == $past(wdata_i))
        else $error("Counter a did not take the written value");

    chk_load_b: assert property (
        cnt_wr[1] |=> st_ff.cnt[1] == $past(wdata_i))
        else $error("Counter b did not take the written value");

    // Prescaler pulse lasts one clock unless it divides by one
    chk_tick_width: assert property (
        PRESCALE > 8'h01 && st_ff.tick |=> !st_ff.tick)
        else $error("Prescaler pulse lasted more than one clock");

    // ---------------------------------------------------------------
    // Register port checks
    // ---------------------------------------------------------------

    chk_clear_flag_a: assert property (
        clr_wr && wdata_i[0] && !set_irq[0] |=> !st_ff.status.ext_irq_flag[0])
        else $error("Clear left flag a set");

    chk_clear_flag_b: assert property (
        clr_wr && wdata_i[1] && !set_irq[1] |=> !st_ff.status.ext_irq_flag[1])
        else $error("Clear left flag b set");

    // Same-cycle event beats the clear
    chk_set_wins_a: assert property (
        clr_wr && set_irq[0] |=> st_ff.status.ext_irq_flag[0])
        else $error("Clear swallowed an event on pin a");

    chk_set_wins_b: assert property (
        clr_wr && set_irq[1] |=> st_ff.status.ext_irq_flag[1])
        else $error("Clear swallowed an event on pin b");

    chk_ctrl_load: assert property (
        ctrl_wr |=> st_ff.ctrl == $past(wdata_i[7:0]))
        else $error("Control did not take the written value");

    chk_enable_load: assert property (
        en_wr |=> st_ff.enable == $past(wdata_i[3:0]))
        else $error("Enable did not take the written value");

    chk_rdata_cnt_a: assert property (
        rd_i && addr_i == `EIT_OFF_CNT_A |=> rdata_o == $past(st_ff.cnt[0]))
        else $error("Read of counter a returned a stale value");

    chk_rdata_cnt_b: assert property (
        rd_i && addr_i == `EIT_OFF_CNT_B |=> rdata_o == $past(st_ff.cnt[1]))
        else $error("Read of counter b returned a stale value");

    cov_edge_irq: cover property (
        st_ff.ctrl.edge_select[0] && fall[0] ##2 irq_o);
    cov_level_irq: cover property (
        !st_ff.ctrl.edge_select[1] && !st_ff.sync2[1] ##1 st_ff.status.ext_irq_flag[1]);
    cov_gated_run: cover property (
        st_ff.ctrl.run_gate_select[0] && st_ff.ctrl.run[0] && inc[0]);
    cov_overflow: cover property (ovf_hit[1]);
    cov_timer_tick: cover property (
        !st_ff.ctrl.cnt_mode[0] && inc[0]);

endmodule

// *** testbench/eit_pin_model.sv ***
`timescale 1ns/1ps

// ------------------------------------------------------------
// External logic on the four pins
// ------------------------------------------------------------
module eit_pin_model (
    input  wire logic       clk_i,
    output logic      [3:0] pins_o
);
    // Port pins have pull-ups, so idle is high
    initial pins_o = 4'hf;

    // Index 0/1: interrupt pins a/b, 2/3: count pins a/b
    task automatic drive(input int idx, input logic val);
        @(posedge clk_i);
        pins_o[idx] <= val;
    endtask

    // Slow or prompt edges; keep each level at least two clocks
    task automatic pulse(input int idx, input int low_cyc, input int high_cyc);
        drive(idx, 1'b0);
        repeat (low_cyc - 1) @(posedge clk_i);
        drive(idx, 1'b1);
        repeat (high_cyc - 1) @(posedge clk_i);
    endtask
endmodule

// *** testbench/eit_inputs_tb.sv ***
`timescale 1ns/1ps
`include "eit_regs.svh"

module eit_inputs_tb;
    logic        clk_i;
    logic        rst_n_i;
    logic        wr_i;
    logic        rd_i;
    logic [3:0]  pins;
    logic [3:0]  addr_i;
    logic [15:0] wdata_i;
    logic [15:0] rdata_o;
    logic        irq_o;
    logic        flag_a;
    logic        flag_b;
    int          error_cnt;
    int          compares;

    eit_pin_model drv_u (.clk_i(clk_i), .pins_o(pins));

    eit_inputs #(.PRESCALE(8'h04)) dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ext_irq_pin_a_i(pins[0]),
        .ext_irq_pin_b_i(pins[1]), .count_pin_a_i(pins[2]), .count_pin_b_i(pins[3]),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .irq_o(irq_o), .ext_irq_flag_a_o(flag_a),
        .ext_irq_flag_b_o(flag_b)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // Access and compare helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge clk_i);
        rd_i <= 1'b1; addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(what, exp, rdata_o);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 4'h0; wdata_i = 16'h0000;
        error_cnt = 0; compares = 0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Reset values, 6 and 7 unmapped
        for (int a = 0; a < 8; a++) rd(a[3:0], 16'h0000, "reset read");
        wr(`EIT_OFF_ENABLE, 16'h000f);
        // Both channels, level mode then edge mode; a pin held low past a clear
        for (int m = 0; m < 2; m++) begin
            for (int ch = 0; ch < 2; ch++) begin
                wr(`EIT_OFF_CTRL, m ? (16'h0001 << ch) : 16'h0000);
                drv_u.drive(ch, 1'b0);
                wait_cyc(2);
                check("flag early", 16'h0000, {14'h0000, flag_b, flag_a});
                wait_cyc(1);
                check("flag", 16'h0001 << ch, {14'h0000, flag_b, flag_a});
                check("irq", 16'h0001, {15'h0000, irq_o});
                wr(`EIT_OFF_ENABLE, 16'h000c);
                #1;
                check("irq masked", 16'h0000, {15'h0000, irq_o});
                wr(`EIT_OFF_ENABLE, 16'h000f);
                wr(`EIT_OFF_STATUS, 16'h0000);
                rd(`EIT_OFF_STATUS, 16'h0001 << ch, "status kept");
                wr(`EIT_OFF_CLEAR, 16'h0001 << ch);
                wait_cyc(3);
                rd(`EIT_OFF_STATUS, m ? 16'h0000 : (16'h0001 << ch), "after clear");
                drv_u.drive(ch, 1'b1);
                wait_cyc(4);
                wr(`EIT_OFF_CLEAR, 16'h000f);
            end
        end
        // Counter mode with wrap, then the run gate
        for (int ch = 0; ch < 2; ch++) begin
            wr(`EIT_OFF_CTRL, 16'h0050 << ch);
            wr(`EIT_OFF_CNT_A + ch[3:0], 16'hfffe);
            repeat (3) drv_u.pulse(2 + ch, 2, 2);
            wait_cyc(4);
            rd(`EIT_OFF_CNT_A + ch[3:0], 16'h0001, "count wrap");
            rd(`EIT_OFF_STATUS, 16'h0004 << ch, "overflow");
            wr(`EIT_OFF_CTRL, 16'h0054 << ch);
            drv_u.drive(ch, 1'b0);
            wait_cyc(4);
            repeat (2) drv_u.pulse(2 + ch, 3, 2);
            wait_cyc(4);
            rd(`EIT_OFF_CNT_A + ch[3:0], 16'h0001, "gate closed");
            drv_u.drive(ch, 1'b1);
            wait_cyc(4);
            repeat (2) drv_u.pulse(2 + ch, 2, 3);
            wait_cyc(4);
            rd(`EIT_OFF_CNT_A + ch[3:0], 16'h0003, "gate open");
            wr(`EIT_OFF_CLEAR, 16'h000f);
        end
        // Timer mode, gate pin high: 40 running clocks at a divide of 4 give 10
        wr(`EIT_OFF_CNT_A, 16'h0000);
        wr(`EIT_OFF_CTRL, 16'h0014);
        wait_cyc(38);
        wr(`EIT_OFF_CTRL, 16'h0000);
        rd(`EIT_OFF_CNT_A, 16'h000a, "timer ticks");
        give_verdict();
    end

    // Whole run needs well under 2000 clocks
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        give_verdict();
    end
endmodule
